//--- design/scad_decode.sv
`timescale 1ns/1ps
`default_nettype none
//Contract
// - transfers complete only while the core is privileged.
// - direction clear writes the general register to the coproc register.
// - direction set returns the coproc register to the general register.
// - system coproc data-op, load and store words raise undefined.
// - a transfer needs bits 27:24 = 1110, 11:8 all ones and bit 4 one.
// - bits 3:0 give the secondary coprocessor register.
// - bits 7:5 give the secondary operation code.
// - bits 15:12 pick the general register; the pc is unpredictable.
// - bits 19:16 give the primary coprocessor register number.
// - bits 23:21 give the primary operation code.
module scad_decode
  import scad_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire logic privileged,
  input wire logic [3:0] nzcv,
  input wire logic [31:0] gpr_rdata,
  input wire logic [31:0] cp_rdata,
  output logic [3:0] gpr_raddr,
  output logic cp_we,
  output logic cp_re,
  output logic [3:0] cp_primary,
  output logic [3:0] cp_secondary,
  output logic [2:0] cp_op1,
  output logic [2:0] cp_op2,
  output logic [31:0] cp_wdata,
  output logic gpr_we,
  output logic [3:0] gpr_waddr,
  output logic [31:0] gpr_wdata,
  output logic undef_exc,
  output logic pc_selected,
  output logic done
);
  typedef struct packed {
    logic cp_we;
    logic cp_re;
    logic [3:0] pri;
    logic [3:0] sec;
    logic [2:0] op1;
    logic [2:0] op2;
    logic [31:0] cp_wdata;
    logic gpr_we;
    logic [3:0] gpr_waddr;
    logic [31:0] gpr_wdata;
    logic undef;
    logic pc_sel;
    logic done;
  } scad_state_type;

  scad_state_type s_q, s_d;
  logic cond_pass;
  logic is_xfer, is_sys, is_other;
  logic [3:0] class_f;

  scad_cond_eval u_cond (
    .cond(instr[SCAD_COND_HI:SCAD_COND_LO]),
    .nzcv(nzcv),
    .pass(cond_pass)
  );

  assign class_f = instr[SCAD_CLASS_HI:SCAD_CLASS_LO];
  assign is_sys = instr[SCAD_CPNUM_HI:SCAD_CPNUM_LO] == SCAD_SYS_CPNUM;
  assign is_xfer = class_f == SCAD_CLASS_XFER && is_sys
    && instr[SCAD_XFER_BIT];
  // data-op (class e, bit4 low) and load/store (class c/d)
  assign is_other = is_sys && ((class_f == SCAD_CLASS_XFER
    && !instr[SCAD_XFER_BIT]) || class_f == SCAD_CLASS_LDST_A
    || class_f == SCAD_CLASS_LDST_B);
  assign gpr_raddr = instr[SCAD_GPR_HI:SCAD_GPR_LO];

  always_comb begin
    s_d = s_q;
    s_d.cp_we = 1'b0;
    s_d.cp_re = 1'b0;
    s_d.gpr_we = 1'b0;
    s_d.undef = 1'b0;
    s_d.done = 1'b0;
    s_d.pc_sel = 1'b0;
    if (instr_valid && cond_pass) begin
      if (is_xfer) begin
        s_d.pri = instr[SCAD_PRI_HI:SCAD_PRI_LO];
        s_d.sec = instr[SCAD_SEC_HI:SCAD_SEC_LO];
        s_d.op1 = instr[SCAD_OP1_HI:SCAD_OP1_LO];
        s_d.op2 = instr[SCAD_OP2_HI:SCAD_OP2_LO];
        s_d.gpr_waddr = instr[SCAD_GPR_HI:SCAD_GPR_LO];
        s_d.pc_sel = instr[SCAD_GPR_HI:SCAD_GPR_LO] == SCAD_PC_INDEX;
        if (!privileged) begin
          s_d.undef = 1'b1;
        end else if (!instr[SCAD_DIR_BIT]) begin
          s_d.cp_we = 1'b1;
          s_d.cp_wdata = gpr_rdata;
          s_d.done = 1'b1;
        end else begin
          s_d.cp_re = 1'b1;
          s_d.done = 1'b1;
        end
      end else if (is_other) begin
        s_d.undef = 1'b1;
      end
    end
    // read data returns the cycle after the read strobe
    if (s_q.cp_re) begin
      s_d.gpr_we = 1'b1;
      s_d.gpr_wdata = cp_rdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.cp_wdata <= SCAD_DATA_RESET;
      s_q.gpr_wdata <= SCAD_DATA_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign cp_we = s_q.cp_we;
  assign cp_re = s_q.cp_re;
  assign cp_primary = s_q.pri;
  assign cp_secondary = s_q.sec;
  assign cp_op1 = s_q.op1;
  assign cp_op2 = s_q.op2;
  assign cp_wdata = s_q.cp_wdata;
  assign gpr_we = s_q.gpr_we;
  assign gpr_waddr = s_q.gpr_waddr;
  assign gpr_wdata = s_q.gpr_wdata;
  assign undef_exc = s_q.undef;
  assign pc_selected = s_q.pc_sel;
  assign done = s_q.done;
endmodule
`default_nettype wire

//--- common/scad_pkg.sv
package scad_pkg;
  // instruction field positions
  localparam int SCAD_COND_HI = 31;
  localparam int SCAD_COND_LO = 28;
  localparam int SCAD_CLASS_HI = 27;
  localparam int SCAD_CLASS_LO = 24;
  localparam int SCAD_OP1_HI = 23;
  localparam int SCAD_OP1_LO = 21;
  localparam int SCAD_DIR_BIT = 20;
  localparam int SCAD_PRI_HI = 19;
  localparam int SCAD_PRI_LO = 16;
  localparam int SCAD_GPR_HI = 15;
  localparam int SCAD_GPR_LO = 12;
  localparam int SCAD_CPNUM_HI = 11;
  localparam int SCAD_CPNUM_LO = 8;
  localparam int SCAD_OP2_HI = 7;
  localparam int SCAD_OP2_LO = 5;
  localparam int SCAD_XFER_BIT = 4;
  localparam int SCAD_SEC_HI = 3;
  localparam int SCAD_SEC_LO = 0;
  // field values
  localparam logic [3:0] SCAD_CLASS_XFER = 4'he;
  localparam logic [3:0] SCAD_CLASS_LDST_A = 4'hc;
  localparam logic [3:0] SCAD_CLASS_LDST_B = 4'hd;
  localparam logic [3:0] SCAD_SYS_CPNUM = 4'hf;
  localparam logic [3:0] SCAD_PC_INDEX = 4'hf;
  localparam logic [31:0] SCAD_DATA_RESET = 32'h0000_0000;
  // flag positions in the nzcv input
  localparam int SCAD_FLAG_N = 3;
  localparam int SCAD_FLAG_Z = 2;
  localparam int SCAD_FLAG_C = 1;
  localparam int SCAD_FLAG_V = 0;
endpackage

//--- design/scad_cond_eval.sv
`timescale 1ns/1ps
`default_nettype none
module scad_cond_eval
  import scad_pkg::*;
(
  input wire logic [3:0] cond,
  input wire logic [3:0] nzcv,
  output logic pass
);
  logic n, z, c, v;
  assign n = nzcv[SCAD_FLAG_N];
  assign z = nzcv[SCAD_FLAG_Z];
  assign c = nzcv[SCAD_FLAG_C];
  assign v = nzcv[SCAD_FLAG_V];
  always_comb begin
    unique case (cond)
      4'h0: pass = z;
      4'h1: pass = !z;
      4'h2: pass = c;
      4'h3: pass = !c;
      4'h4: pass = n;
      4'h5: pass = !n;
      4'h6: pass = v;
      4'h7: pass = !v;
      4'h8: pass = c && !z;
      4'h9: pass = !c || z;
      4'ha: pass = n == v;
      4'hb: pass = n != v;
      4'hc: pass = !z && (n == v);
      4'hd: pass = z || (n != v);
      4'he: pass = 1'b1;
      4'hf: pass = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

//--- verification/scad_props.sv
`timescale 1ns/1ps
`default_nettype none
module scad_props (
  input wire logic core_clk, resetn, privileged, cp_we, cp_re,
  input wire logic gpr_we, undef_exc, done,
  input wire logic [31:0] instr, gpr_rdata, cp_rdata, cp_wdata, gpr_wdata,
  input wire logic [3:0] gpr_raddr, cp_primary, cp_secondary
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  xfer_priv_a: assert property ((cp_we || cp_re) |-> $past(privileged))
    else $error("transfer while unprivileged");
  wr_data_a: assert property (cp_we |-> !$past(instr[20]) &&
    cp_wdata == $past(gpr_rdata)) else $error("bad write data");
  rd_ret_a: assert property (cp_re |=> gpr_we &&
    gpr_wdata == $past(cp_rdata)) else $error("bad read return");
  rd_dir_a: assert property (cp_re |-> $past(instr[20]))
    else $error("read with direction clear");
  done_match_a: assert property (done |-> (cp_we ^ cp_re) &&
    $past(instr[27:24]) == 4'he && $past(instr[4])) else $error("bad done");
  sec_field_a: assert property (done |->
    cp_secondary == $past(instr[3:0])) else $error("bad secondary");
  pri_field_a: assert property (done |->
    cp_primary == $past(instr[19:16])) else $error("bad primary");
  gpr_sel_a: assert property (gpr_raddr == instr[15:12])
    else $error("bad register select");
  undef_clean_a: assert property (undef_exc |-> !done && !cp_we)
    else $error("undefined with transfer");
  cover property (cp_we);
  cover property (cp_re ##1 gpr_we);
  cover property (undef_exc);
endmodule
bind scad_decode scad_props i_scad_props (.core_clk, .resetn, .privileged,
  .cp_we, .cp_re, .gpr_we, .undef_exc, .done, .instr, .gpr_rdata, .cp_rdata,
  .cp_wdata, .gpr_wdata, .gpr_raddr, .cp_primary, .cp_secondary);
`default_nettype wire

//--- verification/scad_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module scad_core_model (
  input wire logic [3:0] gpr_raddr,
  output logic [31:0] gpr_rdata
);
  // each register reads back its index in every nibble; the bench only
  // selects the pc to probe the flag for that unpredictable case
  assign gpr_rdata = {8{gpr_raddr}};
endmodule
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic instr_valid = 1'b0;
  logic privileged = 1'b0;
  logic [3:0] nzcv = 4'h0;
  logic [31:0] instr = 32'h0000_0000;
  logic [31:0] cp_rdata = 32'h5a5a_c3c3;
  logic [31:0] gpr_rdata, cp_wdata, gpr_wdata;
  logic [3:0] gpr_raddr, cp_primary, cp_secondary, gpr_waddr;
  logic [2:0] cp_op1, cp_op2;
  logic cp_we, cp_re, gpr_we, undef_exc, pc_selected, done;
  int fails = 0;
  int n_checks = 0;
  scad_decode i_scad_decode (.core_clk, .resetn, .instr_valid, .instr,
    .privileged, .nzcv, .gpr_rdata, .cp_rdata, .gpr_raddr, .cp_we, .cp_re,
    .cp_primary, .cp_secondary, .cp_op1, .cp_op2, .cp_wdata, .gpr_we,
    .gpr_waddr, .gpr_wdata, .undef_exc, .pc_selected, .done);
  scad_core_model i_scad_core_model (.gpr_raddr, .gpr_rdata);
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic run(logic [31:0] w, logic p);
    @(negedge core_clk);
    instr = w;
    privileged = p;
    instr_valid = 1'b1;
    @(negedge core_clk);
    instr_valid = 1'b0;
  endtask
  task automatic t_write;
    run(32'hee23_2f55, 1'b1);
    chk("cp_we", cp_we, 32'h1);
    chk("cp_wdata", cp_wdata, {8{4'h2}});
    chk("op fields", {cp_op1, cp_op2}, 32'h0a);
    chk("reg fields", {cp_primary, cp_secondary}, 32'h35);
    $display("t_write end");
  endtask
  task automatic t_read;
    run(32'hee34_6f17, 1'b1);
    chk("cp_re", cp_re, 32'h1);
    @(negedge core_clk);
    chk("gpr_we", gpr_we, 32'h1);
    chk("gpr_wdata", gpr_wdata, 32'h5a5a_c3c3);
    chk("gpr_waddr", gpr_waddr, 32'h6);
    $display("t_read end");
  endtask
  task automatic t_refuse;
    logic [31:0] w [8] = '{32'hee23_2f55, 32'h0e23_2f55, 32'hee23_2e55,
      32'hee23_2f45, 32'hec23_2f55, 32'hed23_2f55, 32'hee23_ff55,
      32'h1e23_2f55};
    logic [2:0] e [8] = '{3'h1, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h6, 3'h2};
    for (int i = 0; i < 8; i++) begin
      run(w[i], i != 0);
      chk("pdu", {pc_selected, done, undef_exc}, e[i]);
      chk("cp_we", cp_we, e[i][1]);
    end
    $display("t_refuse end");
  endtask
  task automatic t_cond;
    nzcv = 4'h4;
    run(32'h0e23_2f55, 1'b1);
    chk("eq done", done, 32'h1);
    run(32'h1e23_2f55, 1'b1);
    chk("ne done", done, 32'h0);
    nzcv = 4'h9;
    run(32'hbe23_2f55, 1'b1);
    chk("lt done", done, 32'h0);
    run(32'hae23_2f55, 1'b1);
    chk("ge done", done, 32'h1);
    nzcv = 4'h0;
    $display("t_cond end");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge core_clk);
    resetn = 1'b1;
    t_write;
    t_read;
    t_refuse;
    t_cond;
    give_verdict;
  end
  initial begin
    #20000;
    fails++;
    give_verdict;
  end
endmodule
`default_nettype wire
